// ### pbm_pkg.sv
package pbm_pkg;

  // ==========================================================================
  // register map (word addresses, byte address = 4 * word)
  // ==========================================================================
  localparam logic [3:0] ADDR_DATA    = 4'h0; // output data
  localparam logic [3:0] ADDR_DIR     = 4'h1; // 1 = output
  localparam logic [3:0] ADDR_PULL_EN = 4'h2; // 1 = pull resistor on
  localparam logic [3:0] ADDR_PULL_UP = 4'h3; // 1 = pull-high, 0 = pull-low
  localparam logic [3:0] ADDR_IN_EN   = 4'h4; // port_b_input_enable
  localparam logic [3:0] ADDR_PIN     = 4'h5; // pin read-back (RO)
  localparam logic [3:0] ADDR_ALT     = 4'h6; // pwm routing
  localparam logic [3:0] ADDR_EDGE    = 4'h7; // irq source and edge choice
  localparam logic [3:0] ADDR_STAT    = 4'h8; // sticky events, write one clears
  localparam logic [3:0] ADDR_MASK    = 4'h9; // interrupt mask

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] RST_DATA    = 8'h00;
  localparam logic [7:0] RST_DIR     = 8'h00;
  localparam logic [7:0] RST_PULL_EN = 8'h00;
  localparam logic [7:0] RST_PULL_UP = 8'h00;
  localparam logic [7:0] RST_IN_EN   = 8'hff;
  localparam logic [3:0] RST_ALT     = 4'h0;
  localparam logic [5:0] RST_EDGE    = 6'h00;
  localparam logic [2:0] RST_MASK    = 3'h0;

  // ==========================================================================
  // field positions
  // ==========================================================================
  // alt register bits
  localparam int ALT_T3_PIN6 = 0;
  localparam int ALT_T3_PIN5 = 1;
  localparam int ALT_T2_PIN4 = 2;
  localparam int ALT_T2_PIN2 = 3;
  // status / mask bits
  localparam int ST_IRQ0 = 0;
  localparam int ST_IRQ1 = 1;
  localparam int ST_WAKE = 2;
  // pins that carry the external irq lines and pwm
  localparam int PIN_IRQ0 = 5;
  localparam int PIN_IRQ1 = 0;
  localparam int PIN_T3_A = 6;
  localparam int PIN_T3_B = 5;
  localparam int PIN_T2_A = 4;
  localparam int PIN_T2_B = 2;
  // edge register: [0] irq0 source enable, [2:1] irq0 edge, [3] irq1 en, [5:4] edge
  localparam int EDGE_SRC0 = 0;
  localparam int EDGE_SEL0 = 1;
  localparam int EDGE_SRC1 = 3;
  localparam int EDGE_SEL1 = 4;

  // edge choice encoding
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  // per-pin pad controls
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } pbm_pad_s;

  // avalon request bundle
  typedef struct packed {
    logic [3:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
  } pbm_req_s;

endpackage : pbm_pkg

// ### pbm_edge_det.sv
`timescale 1ns/1ps
module pbm_edge_det
  import pbm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       level,
  input  wire logic [1:0] edge_sel,
  output logic            hit
);
  logic prev_ff;

  // ==========================================================================
  // edge detection on an already synchronised level
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level;
    end
  end

  // selectable rising / falling / both
  always_comb begin
    unique case (edge_sel)
      EDGE_RISE: hit = level & ~prev_ff;
      EDGE_FALL: hit = ~level & prev_ff;
      default:   hit = level ^ prev_ff;
    endcase
  end

endmodule : pbm_edge_det

// ### pbm_port_b_mux.sv
// Summary of operation
// - each pin settable as input or output, with own pull-high or pull-low
// - input-enable bit zero switches off that pin's digital input path
// - pin change wakes from power-down only while its input-enable bit is set
// - pin five selectable as source of external interrupt line zero
// - pin zero selectable as source of external interrupt line one
// - interrupt line fires on rising, falling or both edges, chosen by register
// - timer three pwm routable to pins six and five
// - timer two pwm routable to pins four and two
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
module pbm_port_b_mux
  import pbm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // pads
  input  wire logic [7:0]  pad_in,
  output pbm_pkg::pbm_pad_s pad_ctrl,
  // on-chip sources and sinks
  input  wire logic        timer_three_pwm_out,
  input  wire logic        timer_two_pwm_out,
  input  wire logic        power_down,
  output logic             ext_irq_line_zero,
  output logic             ext_irq_line_one,
  output logic             wake_req,
  output logic             irq
);
  import pbm_pkg::*;

  logic [7:0]  data_ff, dir_ff, pull_en_ff, pull_up_ff, in_en_ff;
  logic [3:0]  alt_ff;
  logic [5:0]  edge_ff;
  logic [2:0]  stat_ff, mask_ff;
  logic [7:0]  sync1_ff, sync2_ff, gated_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  pbm_pad_s    pad_ff;
  logic        irq0_ff, irq1_ff, wake_ff, irq_ff;
  logic [7:0]  gated;
  logic        hit0, hit1, wake_hit;
  logic [7:0]  nxt_out;
  logic [7:0]  alt_oe;
  logic [2:0]  events;
  pbm_req_s    req;
  logic        wr_go, rd_go;

  assign req   = '{addr: avs_address, rd: avs_read, wr: avs_write, wdata: avs_writedata};
  assign wr_go = req.wr & ~ack_ff;
  assign rd_go = req.rd & ~ack_ff;

  // ==========================================================================
  // bus slave: one wait cycle, answer on the second edge
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (req.rd | req.wr) & ~ack_ff;
    end
  end

  assign avs_waitrequest = ~ack_ff;

  // configuration registers, written on the first edge of a request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_ff    <= RST_DATA;
      dir_ff     <= RST_DIR;
      pull_en_ff <= RST_PULL_EN;
      pull_up_ff <= RST_PULL_UP;
      in_en_ff   <= RST_IN_EN;
      alt_ff     <= RST_ALT;
      edge_ff    <= RST_EDGE;
      mask_ff    <= RST_MASK;
    end else if (wr_go) begin
      unique case (req.addr)
        ADDR_DATA:    data_ff    <= req.wdata[7:0];
        ADDR_DIR:     dir_ff     <= req.wdata[7:0];
        ADDR_PULL_EN: pull_en_ff <= req.wdata[7:0];
        ADDR_PULL_UP: pull_up_ff <= req.wdata[7:0];
        ADDR_IN_EN:   in_en_ff   <= req.wdata[7:0];
        ADDR_ALT:     alt_ff     <= req.wdata[3:0];
        ADDR_EDGE:    edge_ff    <= req.wdata[5:0];
        ADDR_MASK:    mask_ff    <= req.wdata[2:0];
        default:      ;
      endcase
    end
  end

  // read mux, data registered for the answering edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0;
    end else if (rd_go) begin
      unique case (req.addr)
        ADDR_DATA:    rdata_ff <= {24'h0, data_ff};
        ADDR_DIR:     rdata_ff <= {24'h0, dir_ff};
        ADDR_PULL_EN: rdata_ff <= {24'h0, pull_en_ff};
        ADDR_PULL_UP: rdata_ff <= {24'h0, pull_up_ff};
        ADDR_IN_EN:   rdata_ff <= {24'h0, in_en_ff};
        ADDR_PIN:     rdata_ff <= {24'h0, gated_ff};
        ADDR_ALT:     rdata_ff <= {28'h0, alt_ff};
        ADDR_EDGE:    rdata_ff <= {26'h0, edge_ff};
        ADDR_STAT:    rdata_ff <= {29'h0, stat_ff};
        ADDR_MASK:    rdata_ff <= {29'h0, mask_ff};
        default:      rdata_ff <= 32'h0;
      endcase
    end
  end

  assign avs_readdata = rdata_ff;

  // ==========================================================================
  // input path: two-stage synchroniser then enable gate
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      gated_ff <= 8'h00;
    end else begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
      gated_ff <= gated;
    end
  end

  // disabled inputs forced low
  assign gated = sync2_ff & in_en_ff;

  // ==========================================================================
  // external interrupt lines and wake-up
  // ==========================================================================
  pbm_edge_det u_edge0 (
    .clk      (clk),
    .rst_n    (rst_n),
    .level    (gated_ff[PIN_IRQ0] & edge_ff[EDGE_SRC0]),
    .edge_sel (edge_ff[EDGE_SEL0 +: 2]),
    .hit      (hit0)
  );

  pbm_edge_det u_edge1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .level    (gated_ff[PIN_IRQ1] & edge_ff[EDGE_SRC1]),
    .edge_sel (edge_ff[EDGE_SEL1 +: 2]),
    .hit      (hit1)
  );

  // any change on an enabled pin while powered down
  assign wake_hit = power_down & (|(gated ^ gated_ff));

  // irq and wake pulses, registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq0_ff <= 1'b0;
      irq1_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      irq0_ff <= hit0;
      irq1_ff <= hit1;
      wake_ff <= wake_hit;
    end
  end

  assign ext_irq_line_zero = irq0_ff;
  assign ext_irq_line_one  = irq1_ff;
  assign wake_req          = wake_ff;

  // ==========================================================================
  // sticky status, write one to clear; set wins
  // ==========================================================================
  assign events = {wake_hit, hit1, hit0};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_ff <= 3'h0;
    end else if (wr_go && req.addr == ADDR_STAT) begin
      stat_ff <= (stat_ff & ~req.wdata[2:0]) | events;
    end else begin
      stat_ff <= stat_ff | events;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  assign irq = irq_ff;

  // ==========================================================================
  // output path: pwm routing and pad controls
  // ==========================================================================
  // a routed pwm replaces the data bit and forces its pin to drive
  always_comb begin
    nxt_out = data_ff;
    alt_oe  = 8'h00;
    if (alt_ff[ALT_T3_PIN6]) begin
      nxt_out[PIN_T3_A] = timer_three_pwm_out;
      alt_oe[PIN_T3_A]  = 1'b1;
    end
    if (alt_ff[ALT_T3_PIN5]) begin
      nxt_out[PIN_T3_B] = timer_three_pwm_out;
      alt_oe[PIN_T3_B]  = 1'b1;
    end
    if (alt_ff[ALT_T2_PIN4]) begin
      nxt_out[PIN_T2_A] = timer_two_pwm_out;
      alt_oe[PIN_T2_A]  = 1'b1;
    end
    if (alt_ff[ALT_T2_PIN2]) begin
      nxt_out[PIN_T2_B] = timer_two_pwm_out;
      alt_oe[PIN_T2_B]  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pad_ff <= '0;
    end else begin
      pad_ff.out       <= nxt_out;
      pad_ff.oe        <= dir_ff | alt_oe;
      pad_ff.pull_up   <= pull_en_ff & pull_up_ff;
      pad_ff.pull_down <= pull_en_ff & ~pull_up_ff;
    end
  end

  assign pad_ctrl = pad_ff;

  // ==========================================================================
  // checks
  // ==========================================================================
  a_gate_low: assert property (
    @(posedge clk) disable iff (!rst_n)
    (in_en_ff != 8'hff) |=> (gated_ff & ~$past(in_en_ff)) == 8'h00)
    else $error("disabled pin reads high");

  a_no_wake_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wake_hit && $stable(in_en_ff)) |-> ((sync2_ff ^ $past(sync2_ff)) & in_en_ff) != 8'h00)
    else $error("wake from disabled pin");

  a_wake_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    wake_hit |=> wake_req)
    else $error("wake not raised");

  a_irq0_fire: assert property (
    @(posedge clk) disable iff (!rst_n)
    hit0 |=> ext_irq_line_zero ##0 stat_ff[ST_IRQ0])
    else $error("irq0 not raised");

  a_irq1_fire: assert property (
    @(posedge clk) disable iff (!rst_n)
    hit1 |=> ext_irq_line_one ##0 stat_ff[ST_IRQ1])
    else $error("irq1 not raised");

  a_irq_off_src: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!edge_ff[EDGE_SRC0] && $past(!edge_ff[EDGE_SRC0], 2)) |-> !hit0)
    else $error("irq0 with source off");

  a_rise_only: assert property (
    @(posedge clk) disable iff (!rst_n)
    (hit1 && edge_ff[EDGE_SEL1 +: 2] == EDGE_RISE) |-> gated_ff[PIN_IRQ1])
    else $error("rise mode fired on fall");

  // switching the source off may legally give one falling edge
  a_fall_only: assert property (
    @(posedge clk) disable iff (!rst_n)
    (hit0 && edge_ff[EDGE_SEL0 +: 2] == EDGE_FALL) |->
      !(gated_ff[PIN_IRQ0] && edge_ff[EDGE_SRC0]))
    else $error("fall mode fired on rise");

  a_w1c_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_go && req.addr == ADDR_STAT && req.wdata[ST_IRQ1] && !hit1) |=> !stat_ff[ST_IRQ1])
    else $error("status bit not cleared");

  a_t3_route: assert property (
    @(posedge clk) disable iff (!rst_n)
    alt_ff[ALT_T3_PIN6] |=> pad_ctrl.out[PIN_T3_A] == $past(timer_three_pwm_out))
    else $error("timer three pwm not routed");

  a_t3_pin5: assert property (
    @(posedge clk) disable iff (!rst_n)
    alt_ff[ALT_T3_PIN5] |=> pad_ctrl.oe[PIN_T3_B] ##0
      pad_ctrl.out[PIN_T3_B] == $past(timer_three_pwm_out))
    else $error("timer three pwm not on pin five");

  a_t2_route: assert property (
    @(posedge clk) disable iff (!rst_n)
    alt_ff[ALT_T2_PIN2] |=> pad_ctrl.oe[PIN_T2_B] ##0
      pad_ctrl.out[PIN_T2_B] == $past(timer_two_pwm_out))
    else $error("timer two pwm not routed");

  a_t2_pin4: assert property (
    @(posedge clk) disable iff (!rst_n)
    alt_ff[ALT_T2_PIN4] |=> pad_ctrl.oe[PIN_T2_A] ##0
      pad_ctrl.out[PIN_T2_A] == $past(timer_two_pwm_out))
    else $error("timer two pwm not on pin four");

  a_dir_drive: assert property (
    @(posedge clk) disable iff (!rst_n)
    (dir_ff != 8'h00) |=> (pad_ctrl.oe & $past(dir_ff)) == $past(dir_ff))
    else $error("output pin not driven");

  a_pull_excl: assert property (
    @(posedge clk) disable iff (!rst_n)
    ##1 (pad_ctrl.pull_up & pad_ctrl.pull_down) == 8'h00)
    else $error("pull-high and pull-low together");

  // every request is answered after exactly one wait cycle
  a_bus_answer: assert property (
    @(posedge clk) disable iff (!rst_n)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus request not answered");

endmodule : pbm_port_b_mux

// ### pbm_board.sv
`timescale 1ns/1ps
module pbm_board
  import pbm_pkg::*;
(
  input  wire logic              clk,
  input  wire pbm_pkg::pbm_pad_s pad_ctrl,
  input  wire logic [7:0]        ext_en,
  input  wire logic [7:0]        ext_val,
  output logic [7:0]             pad_in
);
  // ====================
  // pad levels
  // ====================
  logic flip_ff = 1'b0;

  // floating pins change every cycle so a stale level never reads as valid
  always @(posedge clk) begin
    flip_ff <= ~flip_ff;
  end

  // chip drive wins, then board drive, then the pull resistor
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_ctrl.oe[i]) pad_in[i] = pad_ctrl.out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_ctrl.pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_ctrl.pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = flip_ff;
    end
  end
endmodule : pbm_board

// ### tb_pbm_port_b_mux.sv
`timescale 1ns/1ps
module tb_pbm_port_b_mux;
  import pbm_pkg::*;
  // ====================
  // signals
  // ====================
  logic        clk           = 1'b0;
  logic        rst_n         = 1'b0;
  logic [3:0]  avs_address   = 4'h0;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  pad_in;
  pbm_pad_s    pad_ctrl;
  logic        t3_pwm        = 1'b0;
  logic        t2_pwm        = 1'b0;
  logic        power_down    = 1'b0;
  logic        irq0;
  logic        irq1;
  logic        wake_req;
  logic        irq;
  logic [7:0]  ext_en        = 8'hff;
  logic [7:0]  ext_val       = 8'h00;
  logic [31:0] rd;
  int          failures        = 0;
  int          samples_checked = 0;
  int          n0 = 0;
  int          n1 = 0;
  int          nw = 0;

  pbm_port_b_mux i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
    .pad_ctrl(pad_ctrl), .timer_three_pwm_out(t3_pwm), .timer_two_pwm_out(t2_pwm),
    .power_down(power_down), .ext_irq_line_zero(irq0), .ext_irq_line_one(irq1),
    .wake_req(wake_req), .irq(irq));

  pbm_board i_board (.clk(clk), .pad_ctrl(pad_ctrl), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));

  // clock at 250 MHz
  initial begin
    forever #2 clk = ~clk;
  end

  // count event pulses, one per cycle high
  always @(posedge clk) begin
    if (irq0 === 1'b1) n0++;
    if (irq1 === 1'b1) n1++;
    if (wake_req === 1'b1) nw++;
  end

  // ====================
  // tasks
  // ====================
  task automatic close_out();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr_en;
    avs_read      <= ~wr_en;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 50) begin
      failures++;
      close_out();
    end else begin
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
    end
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask : rdchk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // ====================
  // main sequence
  // ====================
  initial begin
    int b0;
    int b1;
    int bw;
    logic [31:0] e;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("in_en", ADDR_IN_EN, {24'h0, RST_IN_EN});
    rdchk("dir", ADDR_DIR, {24'h0, RST_DIR});
    rdchk("unmapped", 4'hf, 32'h0);
    // directions, levels and pulls per pin; undriven pins read their pull
    ext_en <= 8'h00;
    wr(ADDR_DIR, 32'h0f);
    wr(ADDR_DATA, 32'h05);
    wr(ADDR_PULL_EN, 32'hf0);
    wr(ADDR_PULL_UP, 32'h30);
    cyc(6);
    chk("oe", pad_ctrl.oe, 8'h0f);
    chk("out", pad_ctrl.out & 8'h0f, 8'h05);
    chk("pull_up", pad_ctrl.pull_up, 8'h30);
    chk("pull_dn", pad_ctrl.pull_down, 8'hc0);
    rdchk("pin", ADDR_PIN, 32'h35);
    ext_en <= 8'hff;
    wr(ADDR_DIR, 32'h00);
    wr(ADDR_PULL_EN, 32'h00);
    // pwm routing
    t3_pwm <= 1'b1;
    t2_pwm <= 1'b1;
    wr(ADDR_ALT, 32'h0f);
    cyc(3);
    chk("pwm_oe", pad_ctrl.oe, 8'h74);
    chk("pwm_out", pad_ctrl.out & 8'h74, 8'h74);
    t2_pwm <= 1'b0;
    cyc(3);
    chk("pwm_t2lo", pad_ctrl.out & 8'h74, 8'h60);
    wr(ADDR_ALT, 32'h05);
    cyc(3);
    chk("alt_part", pad_ctrl.oe, 8'h50);
    wr(ADDR_ALT, 32'h00);
    // every edge code on both irq lines
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_EDGE, (c << 1) | (c << 4) | 32'h09);
      b0 = n0;
      b1 = n1;
      ext_val <= 8'h21;
      cyc(8);
      ext_val <= 8'h00;
      cyc(8);
      e = (c == 1 || c == 2) ? 32'h1 : 32'h2;
      chk("irq0_cnt", n0 - b0, e);
      chk("irq1_cnt", n1 - b1, e);
    end
    // sources off: pin edges must reach neither line
    wr(ADDR_EDGE, 32'h00);
    b0 = n0;
    b1 = n1;
    ext_val <= 8'h21;
    cyc(8);
    ext_val <= 8'h00;
    cyc(8);
    chk("irq0_off", n0 - b0, 32'h0);
    chk("irq1_off", n1 - b1, 32'h0);
    // sticky status, mask and write-one clear
    rdchk("stat", ADDR_STAT, 32'h3);
    chk("irq_masked", irq, 1'b0);
    wr(ADDR_MASK, 32'h2);
    cyc(3);
    chk("irq_on", irq, 1'b1);
    wr(ADDR_STAT, 32'h2);
    cyc(3);
    chk("irq_off", irq, 1'b0);
    rdchk("stat_w1c", ADDR_STAT, 32'h1);
    wr(ADDR_STAT, 32'h7);
    // wake only through an enabled pin; disabled pin reads low
    power_down <= 1'b1;
    bw = nw;
    ext_val <= 8'h02;
    cyc(8);
    chk("wake_on", nw - bw, 32'h1);
    rdchk("pin_en", ADDR_PIN, 32'h02);
    ext_val <= 8'h00;
    cyc(8);
    wr(ADDR_IN_EN, 32'hfd);
    bw = nw;
    ext_val <= 8'h02;
    cyc(8);
    chk("wake_off", nw - bw, 32'h0);
    rdchk("pin_dis", ADDR_PIN, 32'h00);
    rdchk("stat_wake", ADDR_STAT, 32'h4);
    power_down <= 1'b0;
    close_out();
  end
endmodule : tb_pbm_port_b_mux
